//--- mqwps_map.vh
// constants for the write-port queue selection block
`ifndef MQWPS_MAP_VH
`define MQWPS_MAP_VH

// ==========================================
// address bus layout
`define MQWPS_ADDR_W 7
`define MQWPS_QSEL_MSB 3
`define MQWPS_QSEL_LSB 0
`define MQWPS_DEV_MSB 6
`define MQWPS_DEV_LSB 4
`define MQWPS_SECTOR_BIT 0

// ==========================================
// sizes
`define MQWPS_NUM_Q 16
`define MQWPS_QID_W 4
`define MQWPS_DEV_W 3
`define MQWPS_DATA_W 36
`define MQWPS_FLAG_W 8
`define MQWPS_FIFO_DEPTH 32
`define MQWPS_FIFO_AW 5

// ==========================================
// reset values
`define MQWPS_RST_QUEUE 4'h0
`define MQWPS_RST_SECTOR 1'b0
`define MQWPS_RST_FLAGS 8'h00

`endif

//--- mqwps_fifo.v
// synchronous valid/ready fifo buffering queue writes
`timescale 1ns/1ns
module mqwps_fifo #(
    parameter WIDTH = 40,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire sys_clk, // write clock
    input wire rst_n, // synchronous reset, active low
    input wire in_valid, // write request
    output wire in_ready, // room for one more word
    input wire [WIDTH-1:0] in_data, // word to store
    output wire out_valid, // a word is waiting
    input wire out_ready, // drain side takes the word
    output wire [WIDTH-1:0] out_data, // oldest word
    output wire [AW:0] level // words held
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];
    assign level = count;

    // storage has no reset; only pointers and count need a defined value
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

//--- mqwps_top.v
// write-port queue selection, write gating and almost-full status bus
// Operation
// - store word only when write enable low
// - queue selection works regardless of write enable
// - new queue written from second cycle on
// - flag bus cycling ignores write enable
// - seven-bit address bus, two purposes
// - low four bits pick one of sixteen
// - top three bits pick matching device
// - capture queue address when strobe high
// - old queue written on selection and next
// - sector strobe captures sector, writes continue
// - bits three to one ignored for sector
// - all flags update on the write clock
`timescale 1ns/1ns
`include "mqwps_map.vh"
module mqwps_top (
    input wire sys_clk, // free-running write clock, 20 MHz
    input wire rst_n, // synchronous reset, active low
    input wire [`MQWPS_DEV_W-1:0] device_id, // expansion identity strap
    input wire poll_mode, // strap: 1 polled flag bus, 0 direct
    input wire serial_program_done_out, // low once programming is done
    input wire [`MQWPS_ADDR_W-1:0] write_queue_addr_bus, // queue or sector address
    input wire write_addr_strobe, // capture queue address
    input wire flag_sector_strobe, // capture flag sector address
    input wire write_en_n, // write enable, active low
    input wire [`MQWPS_DATA_W-1:0] data_in, // write data
    input wire [`MQWPS_NUM_Q-1:0] queue_full_in, // per-queue full from flag logic
    input wire [`MQWPS_NUM_Q-1:0] queue_almost_full_in, // per-queue almost full
    output reg [`MQWPS_QID_W-1:0] active_queue, // queue currently written
    output reg device_selected, // this device owns the write port
    output reg queue_full_flag, // selected queue cannot take a word
    output reg selected_almost_full_flag, // almost full of selected queue
    output reg [`MQWPS_FLAG_W-1:0] almost_full_status_bus, // eight queue flags
    output reg status_sector, // sector shown on the status bus
    output reg status_sync, // polled mode: sector zero on the bus
    output wire write_accepted, // pulse: word taken this edge
    output wire mem_valid, // buffered write waiting
    input wire mem_ready, // queue memory takes the word
    output wire [`MQWPS_QID_W-1:0] mem_queue, // queue of buffered word
    output wire [`MQWPS_DATA_W-1:0] mem_data, // buffered word
    output wire [`MQWPS_FIFO_AW:0] fifo_level // words in the buffer
);
    localparam FIFO_W = `MQWPS_QID_W + `MQWPS_DATA_W;
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_PEND = 2'b10;

    // ==========================================
    // helpers
    function dev_match;
        input [`MQWPS_ADDR_W-1:0] addr;
        input [`MQWPS_DEV_W-1:0] id;
        begin
            dev_match = (addr[`MQWPS_DEV_MSB:`MQWPS_DEV_LSB] == id);
        end
    endfunction

    function [`MQWPS_FLAG_W-1:0] sector_flags;
        input sector;
        input [`MQWPS_NUM_Q-1:0] flags;
        begin
            // bit zero picks the lower or upper group of eight queues
            if (sector) begin
                sector_flags = flags[`MQWPS_NUM_Q-1:`MQWPS_FLAG_W];
            end else begin
                sector_flags = flags[`MQWPS_FLAG_W-1:0];
            end
        end
    endfunction

    // ==========================================
    // strap capture
    reg [`MQWPS_DEV_W-1:0] my_id;
    reg my_poll;

    // straps are sampled while reset is held, so they must be stable then
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            my_id <= device_id;
            my_poll <= poll_mode;
        end
    end

    // ==========================================
    // queue selection pipeline
    reg [1:0] sel_state;
    reg [1:0] next_sel_state;
    reg [`MQWPS_QID_W-1:0] pend_queue;
    reg pend_hit;
    wire prog_done;
    wire queue_sel;
    wire sector_sel;

    // selection is held off until programming is over
    assign prog_done = !serial_program_done_out;
    // write enable plays no part in taking a selection
    assign queue_sel = write_addr_strobe && prog_done;
    // the writer keeps the strobes apart; queue strobe wins if it does not
    assign sector_sel = flag_sector_strobe && !write_addr_strobe;

    always @* begin
        next_sel_state = sel_state;
        case (sel_state)
            ST_IDLE: begin
                if (queue_sel) begin
                    next_sel_state = ST_PEND;
                end
            end
            ST_PEND: begin
                if (!queue_sel) begin
                    next_sel_state = ST_IDLE;
                end
            end
            default: begin
                next_sel_state = ST_IDLE;
            end
        endcase
    end

    // the address is taken at the selection edge, but the write queue only
    // moves one edge later, so the selection edge and the next one still
    // write the old queue and the second edge after writes the new one
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_state <= ST_IDLE;
            pend_queue <= `MQWPS_RST_QUEUE;
            pend_hit <= 1'b0;
            active_queue <= `MQWPS_RST_QUEUE;
            device_selected <= 1'b0;
        end else begin
            sel_state <= next_sel_state;
            if (queue_sel) begin
                pend_queue <= write_queue_addr_bus[`MQWPS_QSEL_MSB:`MQWPS_QSEL_LSB];
                pend_hit <= dev_match(write_queue_addr_bus, my_id);
            end
            if (sel_state == ST_PEND) begin
                active_queue <= pend_queue;
                device_selected <= pend_hit;
            end
        end
    end

    // ==========================================
    // write gating into the buffer
    wire fifo_in_ready;
    wire [FIFO_W-1:0] fifo_out;

    // only a low write enable stores, and only in the owning device
    assign write_accepted = !write_en_n && device_selected && fifo_in_ready
        && !queue_full_in[active_queue];

    mqwps_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(`MQWPS_FIFO_DEPTH),
        .AW(`MQWPS_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(write_accepted),
        .in_ready(fifo_in_ready),
        .in_data({active_queue, data_in}),
        .out_valid(mem_valid),
        .out_ready(mem_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign mem_queue = fifo_out[FIFO_W-1:`MQWPS_DATA_W];
    assign mem_data = fifo_out[`MQWPS_DATA_W-1:0];

    // ==========================================
    // flag sector and status outputs
    reg direct_sector;
    reg next_status_sector;

    // sector strobe needs no write enable and leaves writes alone
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            direct_sector <= `MQWPS_RST_SECTOR;
        end else if (sector_sel && dev_match(write_queue_addr_bus, my_id)) begin
            direct_sector <= write_queue_addr_bus[`MQWPS_SECTOR_BIT];
        end
    end

    always @* begin
        if (my_poll) begin
            next_status_sector = !status_sector;
        end else begin
            next_status_sector = direct_sector;
        end
    end

    // every flag is a flop on the write clock; a stopped clock freezes them
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            status_sector <= `MQWPS_RST_SECTOR;
            status_sync <= 1'b0;
            almost_full_status_bus <= `MQWPS_RST_FLAGS;
            selected_almost_full_flag <= 1'b0;
            queue_full_flag <= 1'b0;
        end else begin
            status_sector <= next_status_sector;
            status_sync <= my_poll && !next_status_sector;
            almost_full_status_bus <= sector_flags(next_status_sector, queue_almost_full_in);
            selected_almost_full_flag <= queue_almost_full_in[active_queue];
            // buffer back-pressure shows as full; it lags one edge
            queue_full_flag <= queue_full_in[active_queue] || !fifo_in_ready;
        end
    end
endmodule

//--- mqwps_asserts.sv
// concurrent checks on the write-port queue selection block
`timescale 1ns/1ns
module mqwps_asserts (
    input wire sys_clk, // write clock
    input wire rst_n, // reset, active low
    input wire [2:0] device_id, // identity strap
    input wire poll_mode, // flag bus mode strap
    input wire serial_program_done_out, // programming busy
    input wire [6:0] write_queue_addr_bus, // queue or sector address
    input wire write_addr_strobe, // queue select strobe
    input wire flag_sector_strobe, // sector select strobe
    input wire write_en_n, // write enable, active low
    input wire [15:0] queue_full_in, // per-queue full
    input wire [3:0] active_queue, // queue written
    input wire device_selected, // port owned
    input wire status_sector, // sector on the bus
    input wire write_accepted, // word taken
    input wire mem_valid, // word buffered
    input wire [3:0] mem_queue, // queue of oldest word
    input wire [5:0] fifo_level // words held
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire sel = write_addr_strobe && !serial_program_done_out;
    gate_write_a: assert property (write_accepted |-> !write_en_n && device_selected)
        else $error("write taken without enable");
    full_block_a: assert property (fifo_level == 6'h20 || queue_full_in[active_queue] |-> !write_accepted)
        else $error("write taken while full");
    queue_pick_a: assert property (sel |-> ##2 active_queue == $past(write_queue_addr_bus[3:0], 2))
        else $error("queue not taken from address");
    dev_match_a: assert property (sel |-> ##2 device_selected == ($past(write_queue_addr_bus[6:4], 2) == device_id))
        else $error("device match wrong");
    sel_hold_a: assert property (!sel |-> ##2 $stable(active_queue))
        else $error("queue changed without strobe");
    sector_pick_a: assert property (flag_sector_strobe && !write_addr_strobe && !poll_mode &&
        write_queue_addr_bus[6:4] == device_id |-> ##2 status_sector == $past(write_queue_addr_bus[0], 2))
        else $error("sector not taken");
    poll_cycle_a: assert property (poll_mode && $past(rst_n, 2) |=> status_sector != $past(status_sector))
        else $error("polled sector not cycling");
    tag_word_a: assert property (write_accepted && fifo_level == 6'h00 |=> mem_valid && mem_queue == $past(active_queue))
        else $error("word tagged with wrong queue");
endmodule
bind mqwps_top mqwps_asserts u_chk (.sys_clk, .rst_n, .device_id, .poll_mode, .serial_program_done_out,
    .write_queue_addr_bus, .write_addr_strobe, .flag_sector_strobe, .write_en_n, .queue_full_in, .active_queue,
    .device_selected, .status_sector, .write_accepted, .mem_valid, .mem_queue, .fifo_level);

//--- mqwps_sink.sv
// queue memory model draining the write buffer
`timescale 1ns/1ns
module mqwps_sink (
    input wire sys_clk, // write clock
    input wire rst_n, // reset, active low
    input wire stall, // hold off pops
    input wire mem_valid, // word waiting
    input wire [3:0] mem_queue, // queue of word
    input wire [35:0] mem_data, // word
    output reg mem_ready // pop enable
);
    logic [39:0] got [0:63];
    integer cnt = 0;
    initial mem_ready = 1'b0;
    always @(posedge sys_clk) begin
        if (rst_n && mem_valid && mem_ready) begin
            got[cnt[5:0]] <= {mem_queue, mem_data};
            cnt <= cnt + 1;
        end
        mem_ready <= rst_n && !stall;
    end
endmodule

//--- mqwps_top_tb.sv
// testbench for the write-port queue selection block
`timescale 1ns/1ns
module mqwps_top_tb;
    localparam ID = 3'h2;
    logic sys_clk, rst_n, poll_mode, serial_program_done_out, write_addr_strobe, flag_sector_strobe, write_en_n, stall;
    logic [6:0] write_queue_addr_bus;
    logic [35:0] data_in;
    logic [15:0] queue_full_in, queue_almost_full_in;
    wire [3:0] active_queue, mem_queue;
    wire device_selected, queue_full_flag, selected_almost_full_flag, status_sector, status_sync;
    wire write_accepted, mem_valid, mem_ready;
    wire [7:0] almost_full_status_bus;
    wire [35:0] mem_data;
    wire [5:0] fifo_level;
    integer num_errors = 0, n_tests = 0, b, i;
    logic s;
    mqwps_top dut (.sys_clk, .rst_n, .device_id(ID), .poll_mode, .serial_program_done_out, .write_queue_addr_bus,
        .write_addr_strobe, .flag_sector_strobe, .write_en_n, .data_in, .queue_full_in, .queue_almost_full_in,
        .active_queue, .device_selected, .queue_full_flag, .selected_almost_full_flag, .almost_full_status_bus,
        .status_sector, .status_sync, .write_accepted, .mem_valid, .mem_ready, .mem_queue, .mem_data, .fifo_level);
    mqwps_sink sink (.sys_clk, .rst_n, .stall, .mem_valid, .mem_queue, .mem_data, .mem_ready);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task chk(input [39:0] seen, input [39:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one cycle of writer activity; strobes never raised together
    task drv(input qs, input fs, input w, input [6:0] a, input [35:0] d);
        @(posedge sys_clk);
        write_addr_strobe <= qs;
        flag_sector_strobe <= fs;
        write_en_n <= w;
        write_queue_addr_bus <= a;
        data_in <= d;
    endtask
    task drain;
        stall <= 1'b0;
        for (i = 0; i < 100 && fifo_level !== 6'h00; i++) cyc(1);
        if (i == 100) begin
            num_errors++;
            close_out;
        end
        cyc(2);
        stall <= 1'b1;
    endtask
    // old queue on selection edge and the next, new queue from the second
    task t_switch;
        drv(1, 0, 1, {ID, 4'h3}, 36'h0);
        drv(0, 0, 1, 7'h00, 36'h0);
        b = sink.cnt;
        drv(1, 0, 0, {ID, 4'h9}, 36'h1);
        drv(0, 0, 0, 7'h00, 36'h2);
        drv(0, 0, 0, 7'h00, 36'h3);
        drv(0, 0, 1, 7'h00, 36'h0);
        drain;
        chk(sink.got[b], {4'h3, 36'h1}, "sel edge");
        chk(sink.got[b + 1], {4'h3, 36'h2}, "next edge");
        chk(sink.got[b + 2], {4'h9, 36'h3}, "new queue");
    endtask
    task t_refuse;
        serial_program_done_out <= 1'b1;
        drv(1, 0, 1, {ID, 4'h7}, 36'h0);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(2);
        chk(active_queue, 4'h9, "prog busy");
        serial_program_done_out <= 1'b0;
        drv(1, 0, 1, {3'h5, 4'h1}, 36'h0);
        // the edge after a selection still writes the old queue, so wait it out
        drv(0, 0, 1, 7'h00, 36'h0);
        drv(0, 0, 0, 7'h00, 36'h4);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(1);
        chk({selected_almost_full_flag, device_selected, fifo_level}, 8'h80, "foreign id");
        drv(1, 0, 1, {ID, 4'h9}, 36'h0);
    endtask
    task t_fill;
        // the selection made at the end of t_refuse owns the port two edges later
        drv(0, 0, 1, 7'h00, 36'h0);
        for (b = 0; b < 33; b++) drv(0, 0, 0, 7'h00, b);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(1);
        chk({queue_full_flag, fifo_level}, 7'h60, "buffer full");
        drain;
        queue_full_in <= 16'h0200;
        drv(0, 0, 0, 7'h00, 36'h5);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(1);
        chk(fifo_level, 6'h00, "queue full");
        queue_full_in <= 16'h0000;
    endtask
    task t_sector;
        drv(0, 1, 1, {ID, 4'hf}, 36'h0);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(1);
        #1 chk({status_sector, almost_full_status_bus}, 9'h1a5, "sector one");
        drv(0, 1, 0, {ID, 4'h0}, 36'h6);
        drv(0, 0, 1, 7'h00, 36'h0);
        cyc(1);
        #1 chk({status_sector, almost_full_status_bus, fifo_level}, 15'h1681, "sector zero");
        drain;
    endtask
    task t_poll;
        poll_mode <= 1'b1;
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(4);
        #1 s = status_sector;
        cyc(1);
        #1 chk({status_sector, status_sync}, {!s, s}, "polled bus");
    endtask
    initial begin
        rst_n = 1'b0;
        poll_mode = 1'b0;
        serial_program_done_out = 1'b0;
        write_addr_strobe = 1'b0;
        flag_sector_strobe = 1'b0;
        write_en_n = 1'b1;
        write_queue_addr_bus = 7'h00;
        data_in = 36'h0;
        queue_full_in = 16'h0000;
        queue_almost_full_in = 16'ha55a;
        stall = 1'b1;
        cyc(16);
        rst_n <= 1'b1;
        cyc(1);
        chk({active_queue, device_selected, mem_valid, fifo_level}, 12'h000, "reset");
        t_switch;
        t_refuse;
        t_fill;
        t_sector;
        t_poll;
        close_out;
    end
endmodule
